/* hdl/wit_defines.vh */
// Constants for the watchdog / interval timer: register indices, field positions, reset values, prescaler masks.
// Assumes an APB master on the same clock; byte address of a register is four times its index.
`ifndef WIT_DEFINES_VH
`define WIT_DEFINES_VH
`define WIT_IDX_W         24
`define WIT_IDX_TCS       24'hFFFF74
`define WIT_IDX_CNT       24'hFFFF75
`define WIT_IDX_RCS_WR    24'hFFFF76
`define WIT_IDX_RCS_RD    24'hFFFF77
`define WIT_IDX_IRQ_STAT  24'hFFFF78
`define WIT_IDX_IRQ_MASK  24'hFFFF79
`define WIT_BIT_OVF       7
`define WIT_BIT_MODE      6
`define WIT_BIT_RUN       5
`define WIT_BIT_WATCHDOG_OVERFLOW_FLAG      7
`define WIT_BIT_INTERNAL_RESET_ENABLE      6
`define WIT_BIT_INTERNAL_RESET_TYPE_SELECT      5
`define WIT_TCS_FIXED     2'h3
`define WIT_RCS_FIXED     5'h1F
`define WIT_CNT_RESET     8'h00
`define WIT_CNT_MAX       8'hFF
`define WIT_MASK_CLOCK_SELECT_BIT0     8'h01
`define WIT_MASK_CLOCK_SELECT_BIT1     8'h03
`define WIT_MASK_CLOCK_SELECT_BIT2     8'h07
`define WIT_MASK_CKS3     8'h0F
`define WIT_MASK_CKS4     8'h1F
`define WIT_MASK_CKS5     8'h3F
`define WIT_MASK_CKS6     8'h7F
`define WIT_MASK_CKS7     8'hFF
`endif

/* hdl/wit_timer.v */
// Watchdog / interval timer with APB register slave and masked interrupt output.
// Assumes APB master on ref_clk; rst_b is the external reset pin, already clean and asynchronous.
`include "wit_defines.vh"
module wit_timer (
	input  wire        ref_clk,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [25:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         irq,
	output reg         internal_reset,
	output reg         internal_reset_manual
);
	reg  [7:0] cnt_reg;
	reg  [7:0] pre_reg;
	reg        ovf_reg;
	reg        mode_reg;
	reg        run_reg;
	reg  [2:0] cks_reg;
	reg        watchdog_overflow_flag_reg;
	reg        internal_reset_enable_reg;
	reg        internal_reset_type_select_reg;
	reg        ovf_armed_reg;
	reg        watchdog_overflow_flag_armed_reg;
	reg  [1:0] stat_reg;
	reg  [1:0] mask_reg;
	reg  [1:0] stat_next;
	reg  [1:0] mask_next;
	reg  [31:0] rd_next;
	reg        err_next;
	wire [`WIT_IDX_W-1:0] idx;
	wire       acc;
	wire       wr;
	wire       rd;
	wire       tick;
	wire       wrap;
	wire       iv_ovf;
	wire       wd_ovf;
	wire [7:0] tcs_val;
	wire [7:0] rcs_val;

	// Prescaler mask per clock select; tick when all masked bits are ones
	// Select 0 divides by two, each higher code doubles the ratio
	// Mask instead of compare: the tick stays one wide AND gate
	// Prescaler not cleared on a select change, so the first tick may come early
	// Limitation: software sees at most one short count period after a change
	// Kept as a function so the ratio table reads in one place
	function [7:0] wit_cks_mask;
		input [2:0] cks;
		begin
			case (cks)
			3'h0: wit_cks_mask = `WIT_MASK_CLOCK_SELECT_BIT0;
			3'h1: wit_cks_mask = `WIT_MASK_CLOCK_SELECT_BIT1;
			3'h2: wit_cks_mask = `WIT_MASK_CLOCK_SELECT_BIT2;
			3'h3: wit_cks_mask = `WIT_MASK_CKS3;
			3'h4: wit_cks_mask = `WIT_MASK_CKS4;
			3'h5: wit_cks_mask = `WIT_MASK_CKS5;
			3'h6: wit_cks_mask = `WIT_MASK_CKS6;
			default: wit_cks_mask = `WIT_MASK_CKS7;
			endcase
		end
	endfunction

	// Bus decode; transfer completes at the access edge with pready high
	// Byte lanes ignored: every register sits in the low byte of a word
	// All side effects key on acc, never on the setup cycle
	// Hazard avoided: a setup cycle alone must not clear or arm anything
	assign idx = paddr[25:2];
	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	assign tick = &(pre_reg | ~wit_cks_mask(cks_reg));
	assign wrap   = tick & run_reg & (cnt_reg == `WIT_CNT_MAX);
	assign iv_ovf = wrap & ~mode_reg;
	assign wd_ovf = wrap & mode_reg;

	// fixed ones in bits 4 and 3
	assign tcs_val = {ovf_reg, mode_reg, run_reg, `WIT_TCS_FIXED, cks_reg};
	assign rcs_val = {watchdog_overflow_flag_reg, internal_reset_enable_reg, internal_reset_type_select_reg, `WIT_RCS_FIXED};

	// Free-running prescaler
	// Runs even while the timer is stopped, so run and stop cost no extra logic
	// Trade-off: the first period after a start is not exact
	// Wraps freely; only its low bits matter for the short ratios
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_reg <= 8'h00;
		end else begin
			pre_reg <= pre_reg + 8'h01;
		end
	end

	// Counter; bus write wins over counting, watchdog overflow clears it
	// Priority: watchdog overflow, stopped, software write, tick
	// A write while stopped is dropped, the count stays zero
	// A write in the tick cycle wins, so that tick is lost
	// Limitation: a write of FF just before a tick still overflows next tick
	// Count value is read back through the read mux unchanged
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= `WIT_CNT_RESET;
		end else if (wd_ovf) begin
			cnt_reg <= `WIT_CNT_RESET;
		end else if (!run_reg) begin
			cnt_reg <= `WIT_CNT_RESET;
		end else if (wr && idx == `WIT_IDX_CNT) begin
			cnt_reg <= pwdata[7:0];
		end else if (tick) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Timer control/status; watchdog overflow resets it like an internal reset
	// Flag bit 7 is never loaded from the bus, only cleared
	// Clear needs a prior read that saw the flag set
	// Any write to this register drops that arming again
	// Hazard: a stray zero write must not lose an unseen overflow
	// Bits 4 and 3 have no storage at all
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovf_reg       <= 1'b0;
			mode_reg      <= 1'b0;
			run_reg       <= 1'b0;
			cks_reg       <= 3'h0;
			ovf_armed_reg <= 1'b0;
		end else if (wd_ovf) begin
			ovf_reg       <= 1'b0;
			mode_reg      <= 1'b0;
			run_reg       <= 1'b0;
			cks_reg       <= 3'h0;
			ovf_armed_reg <= 1'b0;
		end else begin
			if (wr && idx == `WIT_IDX_TCS) begin
				mode_reg <= pwdata[`WIT_BIT_MODE];
				run_reg  <= pwdata[`WIT_BIT_RUN];
				cks_reg  <= pwdata[2:0];
			end
			// set wins over a clear in the same cycle
			if (iv_ovf) begin
				ovf_reg <= 1'b1;
			// write can only clear, and only after a read of 1
			end else if (wr && idx == `WIT_IDX_TCS && !pwdata[`WIT_BIT_OVF] && ovf_armed_reg) begin
				ovf_reg <= 1'b0;
			end
			// arm the clear on a read that saw the flag set
			if (rd && idx == `WIT_IDX_TCS && ovf_reg) begin
				ovf_armed_reg <= 1'b1;
			end else if (wr && idx == `WIT_IDX_TCS) begin
				ovf_armed_reg <= 1'b0;
			end
		end
	end

	// Reset control/status; only the external reset pin reinitialises it
	// The internal reset output is not fed back into this block
	// That keeps the cause of the last reset readable after it
	// Write index and read index differ; both read back the same value
	// Flag clear follows the same read-then-write arming as the timer flag
	// Low five bits are constant ones, no storage
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_overflow_flag_reg       <= 1'b0;
			internal_reset_enable_reg       <= 1'b0;
			internal_reset_type_select_reg       <= 1'b0;
			watchdog_overflow_flag_armed_reg <= 1'b0;
		// nothing here reacts to the internal reset
		end else begin
			if (wr && idx == `WIT_IDX_RCS_WR) begin
				internal_reset_enable_reg <= pwdata[`WIT_BIT_INTERNAL_RESET_ENABLE];
				internal_reset_type_select_reg <= pwdata[`WIT_BIT_INTERNAL_RESET_TYPE_SELECT];
			end
			if (wd_ovf) begin
				watchdog_overflow_flag_reg <= 1'b1;
			end else if (wr && idx == `WIT_IDX_RCS_WR && !pwdata[`WIT_BIT_WATCHDOG_OVERFLOW_FLAG] && watchdog_overflow_flag_armed_reg) begin
				watchdog_overflow_flag_reg <= 1'b0;
			end
			if (rd && idx == `WIT_IDX_RCS_RD && watchdog_overflow_flag_reg) begin
				watchdog_overflow_flag_armed_reg <= 1'b1;
			end else if (wr && idx == `WIT_IDX_RCS_WR) begin
				watchdog_overflow_flag_armed_reg <= 1'b0;
			end
		end
	end

	// Internal reset pulse; the type is held with it for the reset controller
	// Pulse lasts one clock; the reset controller must stretch it if needed
	// Type is held after the pulse so it can be sampled late
	// No pulse while reset enable is off, but counter and control still clear
	// Registered, so the pulse comes one cycle after the wrap
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			internal_reset        <= 1'b0;
			internal_reset_manual <= 1'b0;
		end else begin
			internal_reset <= wd_ovf & internal_reset_enable_reg;
			if (wd_ovf && internal_reset_enable_reg) begin
				internal_reset_manual <= internal_reset_type_select_reg;
			end
		end
	end

	// Sticky interrupt status; a read clears it, but a new event in that cycle wins
	// Bit 0 interval overflow, bit 1 watchdog overflow
	// Hazard avoided: an event in the clearing read cycle is never lost
	// Mask written in the same step so irq follows at once
	// Next values shared with the irq flop for a same-edge update
	always @* begin
		stat_next = stat_reg;
		mask_next = mask_reg;
		if (rd && idx == `WIT_IDX_IRQ_STAT) begin
			stat_next = 2'h0;
		end
		if (iv_ovf) begin
			stat_next[0] = 1'b1;
		end
		if (wd_ovf) begin
			stat_next[1] = 1'b1;
		end
		if (wr && idx == `WIT_IDX_IRQ_MASK) begin
			mask_next = pwdata[1:0];
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_reg <= 2'h0;
			mask_reg <= 2'h0;
			irq      <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			irq      <= |(stat_next & mask_next);
		end
	end

	// Read mux, evaluated in the setup cycle; unmapped indices answer an error
	// Upper data bits are always zero
	// Reads at the write index of reset control also return its value
	// Sampled one cycle early, so an event in the access cycle shows next read
	// Trade-off: zero wait states at the cost of that one-cycle lag
	always @* begin
		rd_next  = 32'h0000_0000;
		err_next = 1'b0;
		if (idx == `WIT_IDX_TCS) begin
			rd_next[7:0] = tcs_val;
		end else if (idx == `WIT_IDX_CNT) begin
			rd_next[7:0] = cnt_reg;
		end else if (idx == `WIT_IDX_RCS_RD || idx == `WIT_IDX_RCS_WR) begin
			rd_next[7:0] = rcs_val;
		end else if (idx == `WIT_IDX_IRQ_STAT) begin
			rd_next[1:0] = stat_reg;
		end else if (idx == `WIT_IDX_IRQ_MASK) begin
			rd_next[1:0] = mask_reg;
		end else begin
			err_next = 1'b1;
		end
	end

	// APB answer: ready in the first access cycle, so no wait states
	// Ready is a pulse, never held between transfers
	// Error rides with ready and only for unmapped indices
	// Read data holds until the next read setup
	// Limitation: the master must not stretch the setup cycle
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & err_next;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_next;
			end
		end
	end
endmodule

/* tb/wit_cpu_model.sv */
// CPU side APB master, one transfer at a time through task xfer.
// Assumes the timer answers on ref_clk; the bench calls the task.
module wit_cpu_model (
	input  logic        ref_clk,
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [25:0] paddr,
	output logic [31:0] pwdata,
	input  logic [31:0] prdata,
	input  logic        pready,
	input  logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	task automatic xfer(input bit w, input logic [23:0] i, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		// Released lines show junk, never the stale request
		psel <= 0;
		penable <= 0;
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

/* tb/wit_timer_chk.sv */
// Port checker for the timer: APB answer timing, fixed bits, reset outputs.
// Assumes one clock domain; rst_b asynchronous, active low.
`include "wit_defines.vh"
module wit_timer_chk (
	input logic        ref_clk,
	input logic        rst_b,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [25:0] paddr,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        internal_reset,
	input logic        internal_reset_manual
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Index decode, as the slave sees it
	wire [23:0] idx = paddr[25:2];
	sequence s_setup; psel && !penable; endsequence
	sequence s_rd; psel && penable && pready && !pwrite; endsequence
	a_ready_pulse: assert property (s_setup |=> pready) else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_map: assert property (pready |-> pslverr == (idx < `WIT_IDX_TCS || idx > `WIT_IDX_IRQ_MASK))
		else $error("error flag wrong for index");
	a_rd_upper: assert property (s_rd |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
	a_tcs_ones: assert property (s_rd ##0 idx == `WIT_IDX_TCS |-> prdata[4:3] == 2'h3)
		else $error("fixed bits not one");
	a_rcs_ones: assert property (s_rd ##0 idx[23:1] == 23'h7FFFBB |-> prdata[4:0] == 5'h1F)
		else $error("reset status low bits wrong");
	a_rst_pulse: assert property (internal_reset |=> !internal_reset) else $error("reset pulse too long");
	a_rst_type: assert property ($changed(internal_reset_manual) |-> internal_reset || $past(internal_reset))
		else $error("reset type moved alone");
endmodule
bind wit_timer wit_timer_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.internal_reset(internal_reset), .internal_reset_manual(internal_reset_manual));

/* tb/wit_timer_tb_top.sv */
// Bench for the timer: reset values, fields, overflow, clear, watchdog reset.
// Assumes the partner model drives APB; seed fixed at 47.
`include "wit_defines.vh"
module wit_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, internal_reset, internal_reset_manual, e;
	logic [25:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] v;
	int err_total, checked, cyc, seed, k;
	wit_timer dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.internal_reset(internal_reset), .internal_reset_manual(internal_reset_manual));
	wit_cpu_model m (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Expected control read: flag clear, fixed ones forced
	function automatic logic [31:0] tcs_exp(input logic [7:0] w);
		return {24'h000000, 1'b0, w[6:5], 2'h3, w[2:0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic rd(input logic [23:0] i);
		m.xfer(0, i, 8'h00, q, e);
	endtask
	task automatic wr(input logic [23:0] i, input logic [7:0] d);
		m.xfer(1, i, d, q, e);
	endtask
	task automatic summarize();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard, far above the longest wait
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		{seed, err_total, checked, cyc, rst_b} = {32'd47, 97'h0};
		repeat (5) @(posedge ref_clk);
		rst_b <= 1;
		rd(`WIT_IDX_TCS); chk("tcs", 32'h18, q);
		rd(`WIT_IDX_RCS_RD); chk("rcs", 32'h1F, q);
		wr(`WIT_IDX_TCS, 8'h87); rd(`WIT_IDX_TCS); chk("tcs", 32'h1F, q);
		wr(`WIT_IDX_CNT, 8'h55); rd(`WIT_IDX_CNT); chk("cnt", 32'h0, q);
		// Every clock select code, run on, interval mode
		for (k = 0; k < 8; k++) begin
			v = 8'h20 | k[7:0];
			wr(`WIT_IDX_TCS, v); rd(`WIT_IDX_TCS); chk("tcs", tcs_exp(v), q);
		end
		v = $random(seed);
		v = v & 8'hFE;
		wr(`WIT_IDX_CNT, v); rd(`WIT_IDX_CNT); chk("cnt", 32'h0, (q - {24'h0, v}) & 32'hFFFF_FFFE);
		wr(`WIT_IDX_IRQ_MASK, 8'h03); wr(`WIT_IDX_TCS, 8'h20); wr(`WIT_IDX_CNT, 8'hFE);
		for (k = 0; k < 50 && irq !== 1'b1; k++) @(posedge ref_clk);
		chk("irq", 1, irq);
		rd(`WIT_IDX_TCS); chk("tcs", 32'hB8, q);
		wr(`WIT_IDX_TCS, 8'hA0); wr(`WIT_IDX_TCS, 8'h20); rd(`WIT_IDX_TCS); chk("tcs", 32'hB8, q);
		wr(`WIT_IDX_TCS, 8'h00); rd(`WIT_IDX_TCS); chk("tcs", 32'h18, q);
		rd(`WIT_IDX_IRQ_STAT); chk("stat", 1, q);
		@(posedge ref_clk); chk("irq", 0, irq);
		wr(`WIT_IDX_RCS_WR, 8'h60); rd(`WIT_IDX_RCS_RD); chk("rcs", 32'h7F, q);
		wr(`WIT_IDX_TCS, 8'h60); wr(`WIT_IDX_CNT, 8'hFE);
		for (k = 0; k < 50 && internal_reset !== 1'b1; k++) @(posedge ref_clk);
		chk("ireset", 1, internal_reset);
		chk("itype", 1, internal_reset_manual);
		rd(`WIT_IDX_RCS_RD); chk("rcs", 32'hFF, q);
		rd(`WIT_IDX_TCS); chk("tcs", 32'h18, q);
		v = $random(seed);
		wr(24'hFFFF7A, v); chk("slverr", 1, e);
		summarize();
	end
endmodule
